// ==== core/ras_pkg.sv ====
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
package ras_pkg;
    localparam int DEPTH = 31;
    localparam int AW    = 21;
    localparam int PW    = 5;
    localparam int STW   = 8;
    localparam int WW    = 8;
    localparam int BW    = 4;

    // Register byte offsets
    localparam logic [7:0] OFS_PTR   = 8'h00;
    localparam logic [7:0] OFS_LOW   = 8'h04;
    localparam logic [7:0] OFS_HIGH  = 8'h08;
    localparam logic [7:0] OFS_UPPER = 8'h0C;

    // Pointer register fields
    localparam int BIT_FULL  = 7;
    localparam int BIT_UNDER = 6;

    localparam logic [PW-1:0] SP_ZERO = 5'h00;
    localparam logic [PW-1:0] SP_ONE  = 5'h01;
    localparam logic [PW-1:0] SP_TOP  = 5'h1F;
    localparam logic [PW-1:0] SP_LAST = 5'h1E;
    localparam logic [AW-1:0] PC_STEP = 21'h0_0002;
    localparam logic [AW-1:0] PC_ZERO = 21'h0_0000;

    typedef enum logic [3:0] {
        PH_ONE   = 4'b0001,
        PH_TWO   = 4'b0010,
        PH_THREE = 4'b0100,
        PH_FOUR  = 4'b1000
    } phase_t;
endpackage

// ==== core/return_address_stack.sv ====
// Our own choices: the address map and register access over AHB-Lite.
`timescale 1ns/1ps
module return_address_stack (
    input  wire logic                      hclk,
    input  wire logic                      hresetn,
    input  wire logic                      hsel,
    input  wire logic [31:0]               haddr,
    input  wire logic [1:0]                htrans,
    input  wire logic                      hwrite,
    input  wire logic [2:0]                hsize,
    input  wire logic [31:0]               hwdata,
    input  wire logic                      hready,
    output logic                           hreadyout,
    output logic                           hresp,
    output logic [31:0]                    hrdata,
    input  wire logic                      dev_reset,
    input  wire logic                      stack_fault_reset_enable,
    input  wire logic                      ext_set_en,
    input  wire logic [ras_pkg::AW-1:0]    pc_in,
    input  wire logic                      op_call,
    input  wire logic                      op_relative_call_op,
    input  wire logic                      int_ack,
    input  wire logic                      op_return,
    input  wire logic                      op_return_with_literal_op,
    input  wire logic                      op_return_from_interrupt_op,
    input  wire logic                      op_add_unlink_return_op,
    input  wire logic                      op_sub_unlink_return_op,
    input  wire logic                      op_push,
    input  wire logic                      op_pop,
    input  wire logic                      op_fast,
    input  wire logic [ras_pkg::STW-1:0]   status_in,
    input  wire logic [ras_pkg::WW-1:0]    working_in,
    input  wire logic [ras_pkg::BW-1:0]    bank_in,
    output ras_pkg::phase_t                phase_q,
    output logic                           pc_inc_q,
    output logic                           ir_latch_q,
    output logic                           dm_rd_q,
    output logic                           dm_wr_q,
    output logic                           flush_q,
    output logic                           pc_load_q,
    output logic [ras_pkg::AW-1:0]         pc_val_q,
    output logic                           reset_req_q,
    output logic                           restore_q,
    output logic [ras_pkg::STW-1:0]        sh_status_q,
    output logic [ras_pkg::WW-1:0]         sh_working_q,
    output logic [ras_pkg::BW-1:0]         sh_bank_q
);
    import ras_pkg::*;

    //////////////////////////////////////////////////////////////////////////
    // Declarations
    logic [AW-1:0] mem_q [1:DEPTH];
    logic [PW-1:0] sp_q;
    logic [PW-1:0] sp_d;
    logic [PW-1:0] sp_inc;
    logic [PW-1:0] sp_dec;
    logic          full_q;
    logic          under_q;
    logic [AW-1:0] tos;
    logic          take;
    logic          push_ev;
    logic          pop_ld;
    logic          pop_sw;
    logic          can_push;
    logic          full_hit;
    logic          under_hit;
    logic          fault_rst;
    logic [AW-1:0] push_val;
    logic          save_ev;
    logic          rest_ev;
    logic          flush_d;
    phase_t        phase_d;
    logic          ap_sel;
    logic          sel_q;
    logic          wr_q;
    logic [7:0]    ofs_q;
    logic          bw_ptr;
    logic          bw_low;
    logic          bw_high;
    logic          bw_upper;
    logic [31:0]   rd_mux;

    //////////////////////////////////////////////////////////////////////////
    // Phase sequencer
    always_comb begin
        case (phase_q)
            PH_ONE:   phase_d = PH_TWO;
            PH_TWO:   phase_d = PH_THREE;
            PH_THREE: phase_d = PH_FOUR;
            PH_FOUR:  phase_d = PH_ONE;
            default:  phase_d = PH_ONE;
        endcase
    end

    // Four non-overlapping phases per instruction cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phase_q <= PH_ONE;
        end else begin
            phase_q <= phase_d;
        end
    end

    // Phase strobes; a flushed prefetch never touches data memory
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pc_inc_q   <= 1'b0;
            ir_latch_q <= 1'b0;
            dm_rd_q    <= 1'b0;
            dm_wr_q    <= 1'b0;
        end else begin
            pc_inc_q   <= (phase_d == PH_ONE);
            ir_latch_q <= (phase_d == PH_FOUR);
            dm_rd_q    <= (phase_d == PH_TWO) && !flush_d;
            dm_wr_q    <= (phase_d == PH_FOUR) && !flush_d;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Operation decode, sampled at the end of phase four
    assign take     = (phase_q == PH_FOUR);
    assign push_ev  = take && (op_call || op_relative_call_op || int_ack || op_push);
    assign pop_ld   = take && !push_ev && (op_return || op_return_with_literal_op || op_return_from_interrupt_op
                      || (ext_set_en && (op_add_unlink_return_op || op_sub_unlink_return_op)));
    assign pop_sw   = take && !push_ev && !pop_ld && op_pop;
    assign sp_inc   = sp_q + SP_ONE;
    assign sp_dec   = sp_q - SP_ONE;
    assign can_push = (sp_q != SP_TOP);
    assign full_hit = push_ev && (sp_q >= SP_LAST);
    assign under_hit = (pop_ld || pop_sw) && (sp_q == SP_ZERO);
    assign fault_rst = stack_fault_reset_enable && (full_hit || under_hit);
    // The 31st push under fault reset stores the counter plus two
    assign push_val = (stack_fault_reset_enable && sp_inc == SP_TOP)
                      ? pc_in + PC_STEP : pc_in;
    assign tos      = (sp_q == SP_ZERO) ? PC_ZERO : mem_q[sp_q];
    assign save_ev  = take && (int_ack || (op_fast && (op_call || op_relative_call_op)));
    assign rest_ev  = pop_ld && op_fast && (op_return_from_interrupt_op || op_return);
    // Only ops that move the counter flush the prefetch; an explicit push stays single cycle
    assign flush_d  = (take) ? ((push_ev && (op_call || op_relative_call_op || int_ack)) || pop_ld)
                      : flush_q;

    //////////////////////////////////////////////////////////////////////////
    // Bus address phase and register decode
    assign ap_sel   = hsel && htrans[1] && hready;
    assign bw_ptr   = sel_q && wr_q && (ofs_q == OFS_PTR);
    assign bw_low   = sel_q && wr_q && (ofs_q == OFS_LOW);
    assign bw_high  = sel_q && wr_q && (ofs_q == OFS_HIGH);
    assign bw_upper = sel_q && wr_q && (ofs_q == OFS_UPPER);

    // Read mux; unmapped offsets read zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (haddr[7:0])
            OFS_PTR:   rd_mux[7:0] = {full_q, under_q, 1'b0, sp_q};
            OFS_LOW:   rd_mux[7:0] = tos[7:0];
            OFS_HIGH:  rd_mux[7:0] = tos[15:8];
            OFS_UPPER: rd_mux[PW-1:0] = tos[AW-1:16];
            default:   rd_mux = 32'h0000_0000;
        endcase
    end

    // Address phase capture
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sel_q <= 1'b0;
            wr_q  <= 1'b0;
            ofs_q <= 8'h00;
        end else begin
            sel_q <= ap_sel;
            wr_q  <= hwrite;
            ofs_q <= haddr[7:0];
        end
    end

    // Zero wait state, always OKAY, read data ready in the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            hrdata    <= 32'h0000_0000;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            if (ap_sel && !hwrite) begin
                hrdata <= rd_mux;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Stack pointer; core operations win over software writes
    always_comb begin
        sp_d = sp_q;
        if (dev_reset || fault_rst) begin
            sp_d = SP_ZERO;
        end else if (push_ev && can_push) begin
            sp_d = sp_inc;
        end else if ((pop_ld || pop_sw) && sp_q != SP_ZERO) begin
            sp_d = sp_dec;
        end else if (bw_ptr) begin
            sp_d = hwdata[PW-1:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sp_q <= SP_ZERO;
        end else begin
            sp_q <= sp_d;
        end
    end

    // Sticky flags; only power-on reset or a software zero clears them
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            full_q  <= 1'b0;
            under_q <= 1'b0;
        end else begin
            if (full_hit) begin
                full_q <= 1'b1;
            end else if (bw_ptr && !hwdata[BIT_FULL]) begin
                full_q <= 1'b0;
            end
            if (under_hit) begin
                under_q <= 1'b1;
            end else if (bw_ptr && !hwdata[BIT_UNDER]) begin
                under_q <= 1'b0;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Stack entries; index zero has no storage
    for (genvar i = 1; i <= DEPTH; i++) begin : g_entry
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                mem_q[i] <= PC_ZERO;
            end else if (push_ev && can_push && sp_inc == PW'(i)) begin
                mem_q[i] <= push_val;
            end else if (sp_q == PW'(i)) begin
                if (bw_low) begin
                    mem_q[i][7:0] <= hwdata[7:0];
                end
                if (bw_high) begin
                    mem_q[i][15:8] <= hwdata[7:0];
                end
                if (bw_upper) begin
                    mem_q[i][AW-1:16] <= hwdata[PW-1:0];
                end
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Program counter load; the latch registers have no path here
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pc_load_q   <= 1'b0;
            pc_val_q    <= PC_ZERO;
            reset_req_q <= 1'b0;
            flush_q     <= 1'b0;
        end else begin
            pc_load_q   <= pop_ld;
            reset_req_q <= fault_rst;
            flush_q     <= flush_d;
            if (pop_ld) begin
                pc_val_q <= tos;
            end
        end
    end

    // Shadow registers; a nested interrupt simply overwrites them
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sh_status_q  <= '0;
            sh_working_q <= '0;
            sh_bank_q    <= '0;
            restore_q    <= 1'b0;
        end else begin
            restore_q <= rest_ev;
            if (save_ev) begin
                sh_status_q  <= status_in;
                sh_working_q <= working_in;
                sh_bank_q    <= bank_in;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Checks
    chk_push_incr: assert property (@(posedge hclk) disable iff (!hresetn)
        push_ev && !dev_reset && sp_q < SP_LAST |=> sp_q == $past(sp_q) + SP_ONE)
        else $error("push did not advance pointer");

    chk_push_store: assert property (@(posedge hclk) disable iff (!hresetn)
        push_ev && !dev_reset && sp_q < SP_LAST |=> tos == $past(pc_in))
        else $error("pushed entry does not hold counter");

    chk_pop_load: assert property (@(posedge hclk) disable iff (!hresetn)
        pop_ld && !dev_reset && sp_q != SP_ZERO
        |=> pc_load_q && pc_val_q == $past(tos) && sp_q == $past(sp_q) - SP_ONE)
        else $error("pop load or decrement wrong");

    chk_under_flag: assert property (@(posedge hclk) disable iff (!hresetn)
        pop_ld && sp_q == SP_ZERO |=> under_q && sp_q == SP_ZERO && pc_val_q == PC_ZERO)
        else $error("underflow handling wrong");

    chk_full_hold: assert property (@(posedge hclk) disable iff (!hresetn)
        push_ev && sp_q == SP_TOP && !dev_reset && !stack_fault_reset_enable
        |=> sp_q == SP_TOP && full_q && $stable(mem_q[DEPTH]))
        else $error("full stack moved or overwritten");

    chk_fault_reset: assert property (@(posedge hclk) disable iff (!hresetn)
        push_ev && sp_q == SP_LAST && stack_fault_reset_enable
        |=> reset_req_q && full_q && sp_q == SP_ZERO
            && mem_q[DEPTH] == $past(pc_in) + PC_STEP)
        else $error("fault reset on full wrong");

    chk_no_reset: assert property (@(posedge hclk) disable iff (!hresetn)
        under_hit && !stack_fault_reset_enable |=> !reset_req_q && under_q)
        else $error("reset raised while disabled");

    chk_phase_walk: assert property (@(posedge hclk) disable iff (!hresetn)
        phase_q == PH_ONE && $past(phase_q) == PH_FOUR |=> phase_q == PH_TWO ##1 phase_q == PH_THREE
            ##1 phase_q == PH_FOUR ##1 phase_q == PH_ONE)
        else $error("phase sequence broken");

    chk_flush_len: assert property (@(posedge hclk) disable iff (!hresetn)
        pop_ld |=> flush_q [*4] ##1
            (flush_q == ($past(take && (op_call || op_relative_call_op || int_ack)) || $past(pop_ld))))
        else $error("flush length wrong");

    chk_shadow_save: assert property (@(posedge hclk) disable iff (!hresetn)
        take && int_ack |=> sh_status_q == $past(status_in)
            && sh_bank_q == $past(bank_in))
        else $error("shadow not saved on interrupt");

    chk_dm_phases: assert property (@(posedge hclk) disable iff (!hresetn)
        dm_rd_q |-> phase_q == PH_TWO && !flush_q)
        else $error("data read outside phase two");

    chk_sw_pop: assert property (@(posedge hclk) disable iff (!hresetn)
        pop_sw && !dev_reset && sp_q != SP_ZERO |=> sp_q == $past(sp_q) - SP_ONE && !pc_load_q)
        else $error("explicit pop wrong");

    chk_push_one_cycle: assert property (@(posedge hclk) disable iff (!hresetn)
        take && op_push && !(op_call || op_relative_call_op || int_ack) |=> !flush_q)
        else $error("explicit push flushed prefetch");
endmodule

// ==== dv/core_seq_model.sv ====
`timescale 1ns/1ps
// Core sequencer stand-in: presents one op set for the phase-four edge only
module core_seq_model
    import ras_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  ras_pkg::phase_t  phase_q,
    input  wire logic [10:0] op_mask,
    input  wire logic        go,
    input  wire logic        bus_busy,
    output logic [10:0]      op_q,
    output logic             done_q
);
    logic act_q;

    // Raise ops in phase three so they stand at the phase-four edge, then report
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            op_q   <= 11'h000;
            act_q  <= 1'b0;
            done_q <= 1'b0;
        end else if (phase_q == PH_THREE && go) begin
            op_q  <= bus_busy ? (op_mask & 11'h7FB) : op_mask;
            act_q <= 1'b1;
        end else if (phase_q == PH_FOUR) begin
            op_q   <= 11'h000;
            done_q <= act_q;
            act_q  <= 1'b0;
        end else begin
            done_q <= 1'b0;
        end
    end
endmodule

// ==== dv/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
    import ras_pkg::*;
    typedef struct packed {
        logic [10:0] m;
        logic        e;
        logic [20:0] pc;
        logic [7:0]  ptr;
        logic        ld;
        logic [20:0] val;
    } row_t;

    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, go, done_q;
    logic        dev_reset, stack_fault_reset_enable, ext;
    logic [31:0] haddr, hwdata, hrdata, rdv;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [10:0] op_mask, op_q;
    logic [20:0] pc_in, pc_val_q, tos, c_val;
    logic [7:0]  st, wk, sh_status_q, sh_working_q;
    logic [3:0]  bk, sh_bank_q, cap, p, q;
    phase_t      phase_q;
    logic        pc_inc_q, ir_latch_q, dm_rd_q, dm_wr_q, flush_q, pc_load_q, reset_req_q;
    logic        restore_q;
    int          errors, check_count, i;
    row_t        rows [13];

    return_address_stack dut_u (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .dev_reset(dev_reset),
        .stack_fault_reset_enable(stack_fault_reset_enable), .ext_set_en(ext), .pc_in(pc_in),
        .op_call(op_q[0]), .op_relative_call_op(op_q[1]), .int_ack(op_q[2]), .op_return(op_q[3]),
        .op_return_with_literal_op(op_q[4]), .op_return_from_interrupt_op(op_q[5]), .op_add_unlink_return_op(op_q[6]), .op_sub_unlink_return_op(op_q[7]),
        .op_push(op_q[8]), .op_pop(op_q[9]), .op_fast(op_q[10]), .status_in(st),
        .working_in(wk), .bank_in(bk), .phase_q(phase_q), .pc_inc_q(pc_inc_q),
        .ir_latch_q(ir_latch_q), .dm_rd_q(dm_rd_q), .dm_wr_q(dm_wr_q), .flush_q(flush_q),
        .pc_load_q(pc_load_q), .pc_val_q(pc_val_q), .reset_req_q(reset_req_q),
        .restore_q(restore_q), .sh_status_q(sh_status_q), .sh_working_q(sh_working_q),
        .sh_bank_q(sh_bank_q)
    );
    core_seq_model seq_u (
        .hclk(hclk), .hresetn(hresetn), .phase_q(phase_q), .op_mask(op_mask), .go(go),
        .bus_busy(htrans[1]), .op_q(op_q), .done_q(done_q)
    );

    // 200 MHz clock
    initial begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Compare, bus and op helpers
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // One single AHB-Lite transfer, zero or more wait states
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr  <= {24'h00_0000, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rdv = hrdata;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string nm);
        bus(1'b0, a, 32'h0000_0000);
        chk(nm, rdv, exp);
    endtask

    task automatic get_tos();
        bus(1'b0, OFS_LOW, 32'h0000_0000);
        tos[7:0] = rdv[7:0];
        bus(1'b0, OFS_HIGH, 32'h0000_0000);
        tos[15:8] = rdv[7:0];
        bus(1'b0, OFS_UPPER, 32'h0000_0000);
        tos[20:16] = rdv[4:0];
    endtask

    // Issue one op and capture the one-cycle answers
    task automatic run_op(input logic [10:0] m, input logic e, input logic [20:0] pc);
        @(posedge hclk);
        op_mask <= m;
        ext     <= e;
        pc_in   <= pc;
        go      <= 1'b1;
        do @(negedge hclk); while (done_q !== 1'b1);
        cap   = {pc_load_q, flush_q, reset_req_q, restore_q};
        c_val = pc_val_q;
        @(posedge hclk);
        go <= 1'b0;
    endtask

    task automatic set_sh(input logic [7:0] s, input logic [7:0] w, input logic [3:0] b);
        @(posedge hclk);
        st <= s;
        wk <= w;
        bk <= b;
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Watchdog
    initial begin
        repeat (20000) @(posedge hclk);
        errors++;
        end_of_test();
    end

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        hresetn = 1'b0;
        {hsel, hwrite, go, dev_reset, stack_fault_reset_enable, ext} = 6'h00;
        {haddr, hwdata} = 64'h0000_0000_0000_0000;
        htrans = 2'b00;
        hsize = 3'b010;
        op_mask = 11'h000;
        pc_in = 21'h0_0000;
        {st, wk, bk} = 20'h0_0000;
        errors = 0;
        check_count = 0;
        rows = '{
            '{11'h001, 1'b0, 21'h0_0100, 8'h01, 1'b0, 21'h0_0000},
            '{11'h002, 1'b0, 21'h0_2468, 8'h02, 1'b0, 21'h0_0000},
            '{11'h004, 1'b0, 21'h1_ABCD, 8'h03, 1'b0, 21'h0_0000},
            '{11'h100, 1'b0, 21'h0_0222, 8'h04, 1'b0, 21'h0_0000},
            '{11'h200, 1'b0, 21'h0_0000, 8'h03, 1'b0, 21'h0_0000},
            '{11'h008, 1'b0, 21'h0_0000, 8'h02, 1'b1, 21'h1_ABCD},
            '{11'h040, 1'b0, 21'h0_0000, 8'h02, 1'b0, 21'h0_0000},
            '{11'h040, 1'b1, 21'h0_0000, 8'h01, 1'b1, 21'h0_2468},
            '{11'h080, 1'b1, 21'h0_0000, 8'h00, 1'b1, 21'h0_0100},
            '{11'h001, 1'b0, 21'h0_0444, 8'h01, 1'b0, 21'h0_0000},
            '{11'h010, 1'b0, 21'h0_0000, 8'h00, 1'b1, 21'h0_0444},
            '{11'h001, 1'b0, 21'h0_0666, 8'h01, 1'b0, 21'h0_0000},
            '{11'h020, 1'b0, 21'h0_0000, 8'h00, 1'b1, 21'h0_0666}};
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;

        // Reset state, pointer fields, empty top, unmapped place
        rchk(OFS_PTR, 32'h0000_0000, "pointer reset");
        rchk(OFS_LOW, 32'h0000_0000, "top at zero");
        bus(1'b1, OFS_LOW, 32'h0000_0077);
        rchk(OFS_LOW, 32'h0000_0000, "top write at zero");
        bus(1'b1, 8'h10, 32'h0000_00FF);
        rchk(8'h10, 32'h0000_0000, "unmapped");
        chk("response", hresp, 1'b0);
        chk("ready", hreadyout, 1'b1);
        bus(1'b1, OFS_PTR, 32'h0000_00E3);
        rchk(OFS_PTR, 32'h0000_0003, "pointer fields");
        bus(1'b1, OFS_PTR, 32'h0000_0000);
        p = phase_q;
        for (i = 0; i < 8; i++) begin
            @(negedge hclk);
            q = {p[2:0], p[3]};
            chk("phase", phase_q, q);
            chk("strobes", {pc_inc_q, dm_rd_q, dm_wr_q, ir_latch_q}, {q[0], q[1], q[3], q[3]});
            p = phase_q;
        end
        $display("test reset and phases finished");

        // Ordinary push and pop cases from the table
        for (i = 0; i < 13; i++) begin
            run_op(rows[i].m, rows[i].e, rows[i].pc);
            chk("pc load", cap[3], rows[i].ld);
            if (rows[i].ld)
                chk("pc value", c_val, rows[i].val);
            chk("flush", cap[2], rows[i].ld | (|rows[i].m[2:0]));
            rchk(OFS_PTR, {24'h00_0000, rows[i].ptr}, "pointer");
            if ((|rows[i].m[2:0]) || rows[i].m[8]) begin
                get_tos();
                chk("top entry", tos, rows[i].pc);
            end
        end
        $display("test table finished");

        // Top entry written by software is what a return loads
        run_op(11'h001, 1'b0, 21'h1_2345);
        bus(1'b1, OFS_LOW, 32'h0000_0055);
        bus(1'b1, OFS_HIGH, 32'h0000_0066);
        bus(1'b1, OFS_UPPER, 32'h0000_0007);
        run_op(11'h008, 1'b0, 21'h0_0000);
        chk("edited return", c_val, 21'h07_6655);
        $display("test top edit finished");

        // Shadow save, overwrite by nested interrupt, fast restore, fast call
        set_sh(8'h5A, 8'hC3, 4'h9);
        run_op(11'h004, 1'b0, 21'h0_0100);
        chk("shadow", {sh_status_q, sh_working_q, sh_bank_q}, 20'h5_AC39);
        set_sh(8'hA5, 8'h3C, 4'h6);
        run_op(11'h004, 1'b0, 21'h0_0200);
        chk("shadow nested", {sh_status_q, sh_working_q, sh_bank_q}, 20'hA_53C6);
        run_op(11'h420, 1'b0, 21'h0_0000);
        chk("restore", cap[0], 1'b1);
        set_sh(8'h11, 8'h22, 4'h3);
        run_op(11'h401, 1'b0, 21'h0_0300);
        chk("shadow call", {sh_status_q, sh_working_q, sh_bank_q}, 20'h1_1223);
        bus(1'b1, OFS_PTR, 32'h0000_0000);
        $display("test shadow finished");

        // Overflow with fault reset disabled
        for (i = 1; i <= 31; i++)
            run_op(11'h001, 1'b0, 21'(2 * i));
        rchk(OFS_PTR, 32'h0000_009F, "full");
        run_op(11'h001, 1'b0, 21'h0_ABCD);
        chk("no fault reset", cap[1], 1'b0);
        rchk(OFS_PTR, 32'h0000_009F, "full held");
        get_tos();
        chk("entry kept", tos, 21'h0_003E);
        bus(1'b1, OFS_PTR, 32'h0000_0000);
        $display("test overflow finished");

        // Underflow, then with fault reset enabled
        run_op(11'h008, 1'b0, 21'h0_0000);
        chk("underflow", {cap[3], c_val, cap[1]}, {1'b1, 21'h0_0000, 1'b0});
        rchk(OFS_PTR, 32'h0000_0040, "underflow flag");
        @(posedge hclk);
        stack_fault_reset_enable <= 1'b1;
        run_op(11'h200, 1'b0, 21'h0_0000);
        chk("underflow reset", cap[1], 1'b1);
        bus(1'b1, OFS_PTR, 32'h0000_0000);
        rchk(OFS_PTR, 32'h0000_0000, "flags cleared");
        $display("test underflow finished");

        // Thirty-first push with fault reset enabled
        bus(1'b1, OFS_PTR, 32'h0000_001E);
        run_op(11'h001, 1'b0, 21'h0_1000);
        chk("fault reset", cap[1], 1'b1);
        rchk(OFS_PTR, 32'h0000_0080, "after fault");
        bus(1'b1, OFS_PTR, 32'h0000_009F);
        get_tos();
        chk("pc plus two", tos, 21'h0_1002);
        @(posedge hclk);
        stack_fault_reset_enable <= 1'b0;
        dev_reset <= 1'b1;
        @(posedge hclk);
        dev_reset <= 1'b0;
        rchk(OFS_PTR, 32'h0000_0080, "device reset");
        @(posedge hclk);
        hresetn <= 1'b0;
        @(posedge hclk);
        hresetn <= 1'b1;
        rchk(OFS_PTR, 32'h0000_0000, "power-on reset");
        $display("test fault reset finished");
        end_of_test();
    end
endmodule
